// ==== design/sgp_gpio_top.sv ====
// Overview of operation
// - six-bit analog port has a software latch per pin, direction per bit.
// - analog port latches keep contents through reset.
// - converter channel select on a port pin, while the converter is active, forces it to analog input.
// - direction 1 drives the pin, 0 makes it an input.
// - reset clears all six analog port direction bits.
// - analog port read gives latch when output, pin level when input.
// - data writes always reach the latch; input pins still read the pin.
// - two-bit port latches are read/write and survive reset.
// - reset clears both two-bit port direction bits.
// - two-bit port read gives latch for outputs, pin for inputs.
// - pullup enable 1 connects pullup on an input two-bit pin.
// - pullup enable 0 leaves an input two-bit pin high impedance.
// - pullup is cut whenever the pin is an output.
// - seven-bit shared port has a read/write latch per pin.
// - seven-bit port latches survive reset.
// - timer edge/level select decides timer or port use of bits 4-6.
// - serial disabled makes bits 0-3 general-purpose I/O.
// - serial pins ignore direction for drive, but direction picks read source.
// - slave-select bit returns to port use when serial is master.
// - analog bit-0 direction never touches slave-select while serial enabled.
// - seven-bit port read gives latch for outputs, pin for inputs.
// - reset clears all seven shared port direction bits.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module sgp_gpio_top (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // analog-shared port pins
   input  wire logic [5:0]  analog_pin_in,
   output logic      [5:0]  analog_pin_out,
   output logic      [5:0]  analog_pin_oe,
   output logic      [5:0]  converter_input_pins,
   input  wire logic        converter_active,
   input  wire logic [4:0]  converter_channel_select,
   // two-bit port pins
   input  wire logic [1:0]  small_pin_in,
   output logic      [1:0]  small_pin_out,
   output logic      [1:0]  small_pin_oe,
   output logic      [1:0]  small_pullup_on,
   // seven-bit shared port pins
   input  wire logic [6:0]  shared_pin_in,
   output logic      [6:0]  shared_pin_out,
   output logic      [6:0]  shared_pin_oe,
   // serial peripheral side
   input  wire logic        serial_periph_enable,
   input  wire logic        serial_periph_master_select,
   input  wire logic [3:0]  serial_out,
   input  wire logic [3:0]  serial_oe,
   output logic      [3:0]  serial_in,
   // timer side: bit 0/1 first timer channels, bit 2 second timer channel
   input  wire logic [5:0]  timer_edge_level_select,
   input  wire logic [2:0]  timer_out,
   input  wire logic [2:0]  timer_oe,
   output logic      [2:0]  timer_in
);
   localparam int AB = sgp_pkg::SGP_ANALOG_BITS;
   localparam int SB = sgp_pkg::SGP_SMALL_BITS;
   localparam int DB = sgp_pkg::SGP_SHARED_BITS;

   // synchronised pin levels
   logic [AB-1:0] analog_sync;
   logic [SB-1:0] small_sync;
   logic [DB-1:0] shared_sync;

   sgp_pin_sync #(.WIDTH(AB)) u_sync_analog (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin_in   (analog_pin_in),
      .pin_sync (analog_sync)
   );
   sgp_pin_sync #(.WIDTH(SB)) u_sync_small (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin_in   (small_pin_in),
      .pin_sync (small_sync)
   );
   sgp_pin_sync #(.WIDTH(DB)) u_sync_shared (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pin_in   (shared_pin_in),
      .pin_sync (shared_sync)
   );

   // address decode
   wire sel_a_data = (reg_addr == sgp_pkg::SGP_OFS_ANALOG_DATA);
   wire sel_c_data = (reg_addr == sgp_pkg::SGP_OFS_SMALL_DATA);
   wire sel_d_data = (reg_addr == sgp_pkg::SGP_OFS_SHARED_DATA);
   wire sel_a_dir  = (reg_addr == sgp_pkg::SGP_OFS_ANALOG_DIR);
   wire sel_c_dir  = (reg_addr == sgp_pkg::SGP_OFS_SMALL_DIR);
   wire sel_d_dir  = (reg_addr == sgp_pkg::SGP_OFS_SHARED_DIR);
   wire sel_c_pu   = (reg_addr == sgp_pkg::SGP_OFS_SMALL_PULLUP);

   logic [AB-1:0] a_latch;
   logic [AB-1:0] a_dir;
   logic [SB-1:0] c_latch;
   logic [SB-1:0] c_dir;
   logic [DB-1:0] d_latch;
   logic [DB-1:0] d_dir;
   logic [7:0]    a_data_rd;
   logic [7:0]    a_dir_rd;
   logic [7:0]    c_data_rd;
   logic [7:0]    c_dir_rd;
   logic [7:0]    d_data_rd;
   logic [7:0]    d_dir_rd;

   // latch written on any data write, reads mux latch/pin per direction
   sgp_port_bits #(.WIDTH(AB)) u_analog (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .data_we   (reg_wr && sel_a_data),
      .dir_we    (reg_wr && sel_a_dir),
      .wdata     (reg_wdata),
      .pin_level (analog_sync),
      .latch_q   (a_latch),
      .dir_q     (a_dir),
      .data_rd   (a_data_rd),
      .dir_rd    (a_dir_rd)
   );
   sgp_port_bits #(.WIDTH(SB)) u_small (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .data_we   (reg_wr && sel_c_data),
      .dir_we    (reg_wr && sel_c_dir),
      .wdata     (reg_wdata),
      .pin_level (small_sync),
      .latch_q   (c_latch),
      .dir_q     (c_dir),
      .data_rd   (c_data_rd),
      .dir_rd    (c_dir_rd)
   );
   sgp_port_bits #(.WIDTH(DB)) u_shared (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .data_we   (reg_wr && sel_d_data),
      .dir_we    (reg_wr && sel_d_dir),
      .wdata     (reg_wdata),
      .pin_level (shared_sync),
      .latch_q   (d_latch),
      .dir_q     (d_dir),
      .data_rd   (d_data_rd),
      .dir_rd    (d_dir_rd)
   );

   // pullup enable register of the two-bit port
   logic [SB-1:0] pullup_reg;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pullup_reg <= sgp_pkg::SGP_PULLUP_RESET[SB-1:0];
      end else if (reg_wr && sel_c_pu) begin
         pullup_reg <= reg_wdata[SB-1:0];
      end
   end

   // read data, valid the cycle after the strobe; unmapped reads zero
   logic [7:0] rdata_next;
   logic [7:0] rdata_reg;
   assign rdata_next = !reg_rd     ? 8'h00 :
                       sel_a_data  ? a_data_rd :
                       sel_c_data  ? c_data_rd :
                       sel_d_data  ? d_data_rd :
                       sel_a_dir   ? a_dir_rd :
                       sel_c_dir   ? c_dir_rd :
                       sel_d_dir   ? d_dir_rd :
                       sel_c_pu    ? 8'({pullup_reg}) : 8'h00;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata = rdata_reg;

   // analog port: selected converter channel overrides direction; the latch still reaches analog_pin_out
   logic [AB-1:0] analog_sel;
   genvar gi;
   generate
      for (gi = 0; gi < AB; gi++) begin : g_analog
         assign analog_sel[gi] = converter_active &&
                                 (converter_channel_select == 5'(gi));
         assign analog_pin_oe[gi]  = a_dir[gi] && !analog_sel[gi];
         assign analog_pin_out[gi] = a_latch[gi];
      end
   endgenerate
   assign converter_input_pins = analog_sel;

   // two-bit port: pullup only on input pins
   assign small_pin_oe    = c_dir;
   assign small_pin_out   = c_latch;
   assign small_pullup_on = pullup_reg & ~c_dir;

   // seven-bit port ownership
   logic [DB-1:0] owned;
   logic [DB-1:0] periph_oe;
   logic [DB-1:0] periph_out;
   // slave select is left to port use in master mode; analog dir never enters here
   assign owned[0] = serial_periph_enable && !serial_periph_master_select;
   assign owned[1] = serial_periph_enable;
   assign owned[2] = serial_periph_enable;
   assign owned[3] = serial_periph_enable;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_timer
         // edge/level select of zero leaves the pin to the port
         assign owned[sgp_pkg::SGP_TIMER_LO + gi] =
            |timer_edge_level_select[2*gi +: 2];
         assign periph_oe[sgp_pkg::SGP_TIMER_LO + gi]  = timer_oe[gi];
         assign periph_out[sgp_pkg::SGP_TIMER_LO + gi] = timer_out[gi];
      end
   endgenerate
   assign periph_oe[3:0]  = serial_oe;
   assign periph_out[3:0] = serial_out;

   generate
      for (gi = 0; gi < DB; gi++) begin : g_shared
         // owned pins ignore direction for drive
         assign shared_pin_oe[gi]  = owned[gi] ? periph_oe[gi]  : d_dir[gi];
         assign shared_pin_out[gi] = owned[gi] ? periph_out[gi] : d_latch[gi];
      end
   endgenerate
   assign serial_in = shared_sync[3:0];
   assign timer_in  = shared_sync[6:4];

   // reference latch for all seven shared port bits, checked against read results
   logic       rd_d_q;
   logic [6:0] exp_d_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rd_d_q  <= 1'b0;
         exp_d_q <= 7'h00;
      end else begin
         rd_d_q  <= reg_rd && sel_d_data;
         exp_d_q <= (d_dir & d_latch) | (~d_dir & shared_sync);
      end
   end

   a_dir_reset: assert property (@(posedge clk_sys)
      !rst_n |=> (a_dir == 6'h00 && c_dir == 2'h0 && d_dir == 7'h00))
      else $error("direction bits not cleared by reset");
   a_shared_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_d_q |-> reg_rdata == {1'b0, exp_d_q})
      else $error("shared port read source wrong");
   a_analog_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && sel_a_data) |=> reg_rdata[7:6] == 2'b00 &&
         reg_rdata[5:0] == (($past(a_dir) & $past(a_latch)) | (~$past(a_dir) & $past(analog_sync))))
      else $error("analog port read source wrong");
   a_write_latch: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_c_data) |=> c_latch == $past(reg_wdata[1:0]))
      else $error("small port latch not written");
   a_pullup_cut: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (small_pullup_on & c_dir) == 2'b00)
      else $error("pullup on while output");
   a_analog_force: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (converter_active && converter_channel_select < 5'd6) |->
         analog_pin_oe[converter_channel_select[2:0]] == 1'b0)
      else $error("converter pin still driven");
   a_ss_master: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (serial_periph_enable && serial_periph_master_select) |->
         shared_pin_oe[0] == d_dir[0])
      else $error("slave select not returned to port in master mode");
   a_timer_own: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (|timer_edge_level_select[1:0]) |-> shared_pin_out[4] == timer_out[0] &&
         shared_pin_oe[4] == timer_oe[0])
      else $error("timer pin not driven by timer");
   a_serial_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !serial_periph_enable |-> shared_pin_oe[3:0] == d_dir[3:0])
      else $error("serial pins not port pins when disabled");

   // read steps: strobe on the small data address, strobe on an unmapped address, no strobe; answer on the following edge
   sequence s_rd_small;
      reg_rd && sel_c_data;
   endsequence
   sequence s_rd_unmapped;
      reg_rd && !(sel_a_data || sel_c_data || sel_d_data || sel_a_dir || sel_c_dir || sel_d_dir || sel_c_pu);
   endsequence
   sequence s_rd_none;
      !reg_rd;
   endsequence

   a_small_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_small |=> reg_rdata == {6'h00,
         (($past(c_dir) & $past(c_latch)) | (~$past(c_dir) & $past(small_sync)))})
      else $error("small port read source wrong");
   a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_unmapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rd_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_rd_none |=> reg_rdata == 8'h00)
      else $error("read data not zero without strobe");
   a_upper_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_rd && sel_d_data) |=> reg_rdata[7] == 1'b0)
      else $error("shared port upper bit not zero");
   a_analog_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_a_data) |=> a_latch == $past(reg_wdata[5:0]))
      else $error("analog port latch not written");
   a_shared_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_d_data) |=> d_latch == $past(reg_wdata[6:0]))
      else $error("shared port latch not written");
   a_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (reg_wr && sel_a_dir) |=> a_dir == $past(reg_wdata[5:0]))
      else $error("analog direction not written");
   a_pullup_reset: assert property (@(posedge clk_sys)
      !rst_n |=> (pullup_reg == 2'b00 && c_dir == 2'b00))
      else $error("two-bit port not cleared by reset");
   a_analog_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !converter_active |-> analog_pin_oe == a_dir)
      else $error("analog drive enable not from direction");
   a_small_oe: assert property (@(posedge clk_sys) disable iff (!rst_n)
      small_pin_oe == c_dir)
      else $error("small drive enable not from direction");
   a_pullup_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (pullup_reg[0] && !c_dir[0]) |-> small_pullup_on[0])
      else $error("pullup not connected on input pin");
   a_pullup_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (~pullup_reg & small_pullup_on) == 2'b00)
      else $error("pullup on without enable");
   a_timer_free: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (timer_edge_level_select[5:4] == 2'b00) |->
         (shared_pin_oe[6] == d_dir[6] && shared_pin_out[6] == d_latch[6]))
      else $error("timer pin not returned to port");
   a_serial_own: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (serial_periph_enable && !serial_periph_master_select) |-> shared_pin_oe[3:0] == serial_oe)
      else $error("serial pins not driven by serial unit");
   a_ss_slave: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (serial_periph_enable && !serial_periph_master_select) |-> shared_pin_oe[0] == serial_oe[0])
      else $error("slave select drive not from serial unit");
   a_conv_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !converter_active |-> converter_input_pins == 6'h00)
      else $error("converter pin claimed while idle");
   a_conv_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $onehot0(converter_input_pins))
      else $error("more than one converter pin claimed");
endmodule // sgp_gpio_top
`default_nettype wire

// ==== design/sgp_pkg.sv ====
package sgp_pkg;
   // register byte offsets on the plain register port
   localparam logic [7:0] SGP_OFS_ANALOG_DATA  = 8'h01;
   localparam logic [7:0] SGP_OFS_SMALL_DATA   = 8'h02;
   localparam logic [7:0] SGP_OFS_SHARED_DATA  = 8'h03;
   localparam logic [7:0] SGP_OFS_ANALOG_DIR   = 8'h05;
   localparam logic [7:0] SGP_OFS_SMALL_DIR    = 8'h06;
   localparam logic [7:0] SGP_OFS_SHARED_DIR   = 8'h07;
   localparam logic [7:0] SGP_OFS_SMALL_PULLUP = 8'h0E;
   // port widths
   localparam int SGP_ANALOG_BITS = 6;
   localparam int SGP_SMALL_BITS  = 2;
   localparam int SGP_SHARED_BITS = 7;
   // reset values of direction and pullup registers
   localparam logic [7:0] SGP_DIR_RESET    = 8'h00;
   localparam logic [7:0] SGP_PULLUP_RESET = 8'h00;
   // bit positions inside the shared port
   localparam int SGP_SS_BIT        = 0;
   localparam int SGP_SERIAL_LO     = 0;
   localparam int SGP_SERIAL_HI     = 3;
   localparam int SGP_TIMER_LO      = 4;
   localparam int SGP_TIMER_HI      = 6;
   // converter channel select field width and pin-input sync depth
   localparam int SGP_CHSEL_BITS    = 5;
   localparam int SGP_SYNC_STAGES   = 3;
endpackage

// ==== design/sgp_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; output changes once stages two and three agree
module sgp_pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] filt_reg;
   wire  [WIDTH-1:0] agree_w = ~(s2_reg ^ s3_reg);
   wire  [WIDTH-1:0] filt_next = (agree_w & s3_reg) | (~agree_w & filt_reg);

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s1_reg   <= '0;
         s2_reg   <= '0;
         s3_reg   <= '0;
         filt_reg <= '0;
      end else begin
         s1_reg   <= pin_in;
         s2_reg   <= s1_reg;
         s3_reg   <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign pin_sync = filt_reg;
endmodule // sgp_pin_sync
`default_nettype wire

// ==== design/sgp_port_bits.sv ====
`timescale 1ns/100ps
`default_nettype none
// per-bit latch, direction and read mux of one port
module sgp_port_bits #(
   parameter int WIDTH = 6
) (
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             data_we,
   input  wire logic             dir_we,
   input  wire logic [7:0]       wdata,
   input  wire logic [WIDTH-1:0] pin_level,
   output logic      [WIDTH-1:0] latch_q,
   output logic      [WIDTH-1:0] dir_q,
   output logic      [7:0]       data_rd,
   output logic      [7:0]       dir_rd
);
   // elaboration-time refusal of widths the byte-wide register port cannot carry
   if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
      $error("port width must be 1..8");
   end

   logic [WIDTH-1:0] latch_reg;
   logic [WIDTH-1:0] dir_reg;
   logic [WIDTH-1:0] mux_w;

   // latch has no reset and is written whatever direction holds
   always_ff @(posedge clk_sys) begin
      if (data_we) begin
         latch_reg <= wdata[WIDTH-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         dir_reg <= sgp_pkg::SGP_DIR_RESET[WIDTH-1:0];
      end else if (dir_we) begin
         dir_reg <= wdata[WIDTH-1:0];
      end
   end

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         assign mux_w[i] = dir_reg[i] ? latch_reg[i] : pin_level[i];
      end
   endgenerate

   assign latch_q = latch_reg;
   assign dir_q   = dir_reg;
   assign data_rd = 8'({mux_w});
   assign dir_rd  = 8'({dir_reg});
endmodule // sgp_port_bits
`default_nettype wire

// ==== testbench/sgp_pin_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// pad model: a driven pad follows the port, a released one follows the outside source or the pullup
module sgp_pin_model (
   input  wire logic [5:0] analog_pin_out,
   input  wire logic [5:0] analog_pin_oe,
   input  wire logic [5:0] analog_ext,
   output logic      [5:0] analog_pin_in,
   input  wire logic [1:0] small_pin_out,
   input  wire logic [1:0] small_pin_oe,
   input  wire logic [1:0] small_pullup_on,
   input  wire logic [1:0] small_ext,
   output logic      [1:0] small_pin_in,
   input  wire logic [6:0] shared_pin_out,
   input  wire logic [6:0] shared_pin_oe,
   input  wire logic [6:0] shared_ext,
   output logic      [6:0] shared_pin_in
);
   assign analog_pin_in = (analog_pin_oe & analog_pin_out) | (~analog_pin_oe & analog_ext);
   // a pulled-up input reads high whatever the outside source offers
   assign small_pin_in  = (small_pin_oe & small_pin_out) |
                          (~small_pin_oe & (small_pullup_on | small_ext));
   assign shared_pin_in = (shared_pin_oe & shared_pin_out) | (~shared_pin_oe & shared_ext);
endmodule // sgp_pin_model
`default_nettype wire

// ==== testbench/shared_gpio_ports_bcd_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module shared_gpio_ports_bcd_tb;
   localparam logic [7:0] OFS [7] = '{sgp_pkg::SGP_OFS_ANALOG_DATA, sgp_pkg::SGP_OFS_SMALL_DATA,
      sgp_pkg::SGP_OFS_SHARED_DATA, sgp_pkg::SGP_OFS_ANALOG_DIR, sgp_pkg::SGP_OFS_SMALL_DIR,
      sgp_pkg::SGP_OFS_SHARED_DIR, sgp_pkg::SGP_OFS_SMALL_PULLUP};
   localparam logic [7:0] MSK [7] = '{8'h3F, 8'h03, 8'h7F, 8'h3F, 8'h03, 8'h7F, 8'h03};
   logic        clk_sys, rst_n, reg_wr, reg_rd, conv_act, sp_en, sp_mst;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic [5:0]  a_out, a_oe, a_in, a_ext, conv_pins, tsel;
   logic [4:0]  conv_sel;
   logic [1:0]  s_out, s_oe, s_in, s_ext, s_pu;
   logic [6:0]  d_out, d_oe, d_in, d_ext;
   logic [3:0]  ser_out, ser_oe, ser_in;
   logic [2:0]  tm_out, tm_oe, tm_in;
   logic [31:0] lfsr, w;
   logic [7:0]  v [7];
   int          bad_count, tests_run;

   sgp_gpio_top u_sgp_gpio_top (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .analog_pin_in(a_in), .analog_pin_out(a_out), .analog_pin_oe(a_oe),
      .converter_input_pins(conv_pins), .converter_active(conv_act), .converter_channel_select(conv_sel),
      .small_pin_in(s_in), .small_pin_out(s_out), .small_pin_oe(s_oe), .small_pullup_on(s_pu),
      .shared_pin_in(d_in), .shared_pin_out(d_out), .shared_pin_oe(d_oe),
      .serial_periph_enable(sp_en), .serial_periph_master_select(sp_mst), .serial_out(ser_out),
      .serial_oe(ser_oe), .serial_in(ser_in), .timer_edge_level_select(tsel), .timer_out(tm_out),
      .timer_oe(tm_oe), .timer_in(tm_in));

   sgp_pin_model u_sgp_pin_model (.analog_pin_out(a_out), .analog_pin_oe(a_oe), .analog_ext(a_ext),
      .analog_pin_in(a_in), .small_pin_out(s_out), .small_pin_oe(s_oe), .small_pullup_on(s_pu),
      .small_ext(s_ext), .small_pin_in(s_in), .shared_pin_out(d_out), .shared_pin_oe(d_oe),
      .shared_ext(d_ext), .shared_pin_in(d_in));

   initial begin
      clk_sys = 1'h0;
      forever #5 clk_sys = ~clk_sys;
   end

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], 1'h0} ^ (lfsr[31] ? 32'h04C11DB7 : 32'h00000000);
      return lfsr;
   endfunction

   function automatic logic [7:0] mux(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
      return (s & a) | (~s & b);
   endfunction

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
   endtask

   // read data stand for one cycle only, then return to zero
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      chk("read data", reg_rdata & m, e & m);
      @(posedge clk_sys);
      #1;
      chk("read idle", reg_rdata, 8'h00);
   endtask

   task automatic reset_check();
      @(posedge clk_sys);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      for (int k = 3; k < 7; k++) rd_chk(OFS[k], 8'h00, 8'hFF);
   endtask

   task automatic check_pins();
      logic [7:0] cs, aoe, pu, own, eoe, eout, e;
      logic [7:0] p [3];
      cs = (conv_act && conv_sel < 5'h06) ? 8'h01 << conv_sel : 8'h00;
      aoe = v[3] & ~cs & 8'h3F;
      pu = v[6] & ~v[4] & 8'h03;
      own = {1'h0, |tsel[5:4], |tsel[3:2], |tsel[1:0], {3{sp_en}}, sp_en & ~sp_mst};
      eoe = mux(own, {1'h0, tm_oe, ser_oe}, v[5] & 8'h7F);
      eout = mux(own, {1'h0, tm_out, ser_out}, v[2] & 8'h7F);
      p[0] = mux(aoe, v[0], {2'h0, a_ext});
      p[1] = mux(v[4], v[1], {6'h0, s_ext} | pu);
      p[2] = mux(eoe, eout, {1'h0, d_ext});
      chk("analog oe", {2'h0, a_oe}, aoe);
      chk("converter pins", {2'h0, conv_pins}, cs);
      chk("analog out", {2'h0, a_out}, v[0] & 8'h3F);
      chk("small oe", {6'h0, s_oe}, v[4] & 8'h03);
      chk("small out", {6'h0, s_out}, v[1] & 8'h03);
      chk("pullup", {6'h0, s_pu}, pu);
      chk("shared oe", {1'h0, d_oe}, eoe);
      chk("shared out", {1'h0, d_out}, eout);
      chk("serial in", {4'h0, ser_in}, p[2] & 8'h0F);
      chk("timer in", {5'h0, tm_in}, {5'h0, p[2][6:4]});
      for (int k = 0; k < 7; k++) begin
         e = (k < 3) ? mux(v[k + 3], v[k], p[k]) : v[k];
         rd_chk(OFS[k], e & MSK[k], 8'hFF);
      end
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      complete_run();
   end

   initial begin
      lfsr = 32'hC2DB57EE;
      {reg_wr, reg_rd, reg_addr, reg_wdata, rst_n} = '0;
      {a_ext, s_ext, d_ext, conv_act, conv_sel, sp_en, sp_mst, ser_out, ser_oe} = '0;
      {tsel, tm_out, tm_oe} = '0;
      bad_count = 0;
      tests_run = 0;
      reset_check();
      for (int i = 0; i < 40; i++) begin
         @(posedge clk_sys);
         w = rnd();
         {a_ext, s_ext, d_ext, conv_act, conv_sel, sp_en, sp_mst, ser_out, ser_oe} <= w[30:0];
         w = rnd();
         {tsel, tm_out, tm_oe} <= w[11:0];
         foreach (v[k]) v[k] = 8'(rnd());
         // latches are loaded ahead of direction so no stale level is driven
         foreach (v[k]) wr(OFS[k], v[k]);
         repeat (8) @(posedge clk_sys);
         #1;
         check_pins();
      end
      reset_check();
      for (int k = 3; k < 6; k++) wr(OFS[k], 8'hFF);
      for (int k = 0; k < 3; k++) rd_chk(OFS[k], v[k] & MSK[k], 8'hFF);
      wr(8'h04, 8'h5A);
      rd_chk(8'h04, 8'h00, 8'hFF);
      complete_run();
   end
endmodule // shared_gpio_ports_bcd_tb
`default_nettype wire
